// [hw/acs_pkg.sv]
// constants, field layouts and mode codes for the conversion sequencer
// assumes a single 50 MHz system clock and an APB register port
// Operation
// - internal sync: convert pulse starts conversion timing
// - wait 4.5 us settling before conversion
// - external sync: hold off until sync pulse
// - gain bits 00..11 give 1,2,4,8
// - interrupt forces sync flop to internal
// - each external pulse converts again while external
// - result is twelve bits plus sign
// - conversion complete after about 35 us
// - sequential: complete enables next convert pulse
// - complete also resets sample and hold
// - upper two channel bits pick multiplexer
// - lower five channel bits pick input
// - up to 128 channels over four multiplexers
// - data strobe drives result onto bus
// - read status drives channel and flags
// - trap address driven complemented onto lines
// - read request drives word count address 26
// - random write drives word count address 24
// - random: load starts; sequential: first from delayed
// - program mode: convert instruction delayed 1 us
package acs_pkg;

  // timing, figures in ns as printed, cycles derived from the clock
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned SETTLE_NS = 4500;
  localparam int unsigned CONV_NS = 35000;
  localparam int unsigned DEL_NS = 1000;
  localparam int unsigned SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CONV_CYC = (CONV_NS * CLK_MHZ) / 1000;
  localparam int unsigned DEL_CYC = (DEL_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 11;

  // apb map, byte addresses
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS_WORD = 12'h004;
  localparam logic [11:0] OFF_RESULT = 12'h008;
  localparam logic [11:0] OFF_STATE = 12'h00C;

  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SYNC_POS = 2;
  localparam logic [1:0] CTRL_MODE_RST = 2'h0;

  // status word fields: channel address then gain
  localparam int CHAN_W = 7;
  localparam int SW_CHAN_LSB = 0;
  localparam int CHAN_GROUP_HIGH_POS = 6;
  localparam int CHAN_GROUP_LOW_POS = 5;
  localparam int CHAN_BIT_FIVE_POS = 1;
  localparam int CHAN_BIT_SIX_POS = 0;
  localparam int GAIN_SEL_LOW_POS = 7;
  localparam int GAIN_SEL_HIGH_POS = 8;
  localparam logic [8:0] SW_RST = 9'h000;

  // result register fields
  localparam int RES_W = 13;
  localparam int RES_DONE_POS = 16;

  // state register fields
  localparam int ST_CHAN_LSB = 0;
  localparam int ST_GAIN_LSB = 7;
  localparam int ST_BUSY_POS = 9;
  localparam int ST_SYNC_POS = 10;
  localparam int ST_WC_POS = 11;
  localparam int ST_MEM_POS = 12;

  // host io bus, index = 17 - host bit number
  localparam int IO_W = 18;
  localparam int OSW_WC_IDX = 13;
  localparam int OSW_MEM_IDX = 12;
  localparam logic [5:0] TRAP_ADDR = 6'h2F;
  localparam logic [5:0] WC_DATA_ADDR = 6'h16;
  localparam logic [5:0] WC_STATUS_ADDR = 6'h14;

  // conversion start sources
  typedef enum logic [1:0] {MODE_PROG, MODE_RANDOM, MODE_SEQ} acs_mode_t;

endpackage : acs_pkg

// [hw/acs_top.sv]
// conversion sequencer: sync choice, settle and convert timing, gain and
// channel decode, result capture and complemented host bus drivers
// assumes host instruction pulses come from logic on sys_clk; the external
// sync pin and converter data pins are asynchronous and are synchronised
//
// Added by the designer: the placing of the registers and the APB slave port.
module acs_top #(
  parameter int unsigned SETTLE_CYC = acs_pkg::SETTLE_CYC,
  parameter int unsigned CONV_CYC = acs_pkg::CONV_CYC,
  parameter int unsigned DEL_CYC = acs_pkg::DEL_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [acs_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic convert_instr,
  input wire logic read_status_instr,
  input wire logic priority_interrupt,
  input wire logic force_internal_sync_n,
  input wire logic data_strobe,
  input wire logic dch_read_req,
  input wire logic dch_write_req,
  input wire logic dch_flag,
  input wire logic wc_overflow,
  input wire logic mem_overflow,
  input wire logic ext_sync_pin,
  input wire logic [acs_pkg::RES_W-1:0] adc_data_pin,
  output logic [3:0] gain_sel,
  output logic [3:0] mux_en,
  output logic [31:0] chan_sel,
  output logic sync_source_select,
  output logic conv_start,
  output logic conv_done,
  output logic sh_reset,
  output logic busy,
  output logic [acs_pkg::IO_W-1:0] io_data_n,
  output logic [5:0] io_addr_n
);

  // refuse counts that the 11-bit counter cannot hold
  generate
    if (SETTLE_CYC < 1 || CONV_CYC < 2 || DEL_CYC < 1 || CONV_CYC >= 2048
        || SETTLE_CYC >= 2048 || DEL_CYC >= 2048)
    begin : g_bad_cnt
      $error("acs_top: timing counts out of range");
    end
  endgenerate

  localparam logic [10:0] SETTLE_LAST = 11'(SETTLE_CYC - 1);
  localparam logic [10:0] CONV_LAST = 11'(CONV_CYC - 1);
  localparam logic [10:0] DEL_LOAD = 11'(DEL_CYC);

  // one-hot decode shared by gain, group and channel selects
  function automatic logic [31:0] acs_onehot(input logic [4:0] idx);
    acs_onehot = 32'h1 << idx;
  endfunction : acs_onehot

  typedef enum logic [1:0] {ST_IDLE, ST_ARM, ST_SETTLE, ST_CONV} acs_state_t;

  acs_state_t state_r; // conversion sequencer state
  logic [10:0] cnt_r; // settle or convert countdown
  logic [10:0] del_r; // convert instruction delay countdown
  acs_pkg::acs_mode_t mode_r; // start source
  logic sync_ext_r; // sync-source flop, 1 = external
  logic [8:0] sw_r; // last loaded status word
  logic [acs_pkg::CHAN_W-1:0] act_chan_r; // channel held for this conversion
  logic [1:0] act_gain_r; // gain held for this conversion
  logic [acs_pkg::RES_W-1:0] result_r; // data buffer
  logic done_r; // sticky conversion complete flag
  logic conv_start_r; // one-cycle start of conversion
  logic conv_done_r; // one-cycle end of conversion
  logic sh_reset_r; // sample and hold reset pulse
  logic ext_q1; // external sync, first stage
  logic ext_q2; // external sync, second stage
  logic ext_q3; // delayed for edge detect
  logic [acs_pkg::RES_W-1:0] adc_q1; // converter data, first stage
  logic [acs_pkg::RES_W-1:0] adc_q2; // converter data, second stage
  logic [3:0] gain_sel_r;
  logic [3:0] mux_en_r;
  logic [31:0] chan_sel_r;
  logic [acs_pkg::IO_W-1:0] io_data_n_r;
  logic [5:0] io_addr_n_r;
  logic [31:0] prdata_r;

  logic ext_pulse; // rising edge of synchronised external sync
  logic del_fire; // delayed convert instruction
  logic load_evt; // status word written over apb
  logic cnv_pulse; // convert pulse from the selected source
  logic apb_setup; // first cycle of an apb transfer
  logic apb_wr; // write takes effect this edge
  logic apb_rd; // read completes this edge
  logic addr_ok; // address hits a register
  logic settle_end; // last settle cycle
  logic conv_end; // last conversion cycle
  logic [8:0] sw_src; // status word seen by a start; a load must convert the new word

  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;
  assign addr_ok = (paddr == acs_pkg::OFF_CTRL) || (paddr == acs_pkg::OFF_STATUS_WORD)
                   || (paddr == acs_pkg::OFF_RESULT) || (paddr == acs_pkg::OFF_STATE);
  assign load_evt = apb_wr && (paddr == acs_pkg::OFF_STATUS_WORD);
  assign sw_src = load_evt ? pwdata[8:0] : sw_r;
  assign ext_pulse = ext_q2 && !ext_q3;
  assign del_fire = (del_r == 11'h001);
  assign settle_end = (state_r == ST_SETTLE) && (cnt_r == 11'h000);
  assign conv_end = (state_r == ST_CONV) && (cnt_r == 11'h000);

  // convert pulse source follows the mode
  always_comb
  begin
    case (mode_r)
      acs_pkg::MODE_RANDOM: cnv_pulse = load_evt;
      acs_pkg::MODE_SEQ: cnv_pulse = del_fire
        || (conv_done_r && dch_flag && !wc_overflow && !mem_overflow);
      acs_pkg::MODE_PROG: cnv_pulse = del_fire;
      default: cnv_pulse = del_fire;
    endcase
  end

  // two-flop synchronisers for the asynchronous pins
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ext_q1 <= 1'b0;
      ext_q2 <= 1'b0;
      ext_q3 <= 1'b0;
      adc_q1 <= '0;
      adc_q2 <= '0;
    end
    else
    begin
      ext_q1 <= ext_sync_pin;
      ext_q2 <= ext_q1;
      ext_q3 <= ext_q2;
      adc_q1 <= adc_data_pin;
      adc_q2 <= adc_q1;
    end
  end

  // convert instruction delay; a new instruction while counting is ignored
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      del_r <= 11'h000;
    else if (convert_instr && del_r == 11'h000)
      del_r <= DEL_LOAD;
    else if (del_r != 11'h000)
      del_r <= del_r - 11'h001;
  end

  // mode and status word registers written by software
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      mode_r <= acs_pkg::acs_mode_t'(acs_pkg::CTRL_MODE_RST);
      sw_r <= acs_pkg::SW_RST;
    end
    else
    begin
      if (apb_wr && paddr == acs_pkg::OFF_CTRL)
        mode_r <= acs_pkg::acs_mode_t'(pwdata[acs_pkg::CTRL_MODE_LSB +: 2]);
      if (load_evt)
        sw_r <= pwdata[8:0];
    end
  end

  // sync-source flop; hardware forcing to internal beats a software write
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      sync_ext_r <= 1'b0;
    else if (priority_interrupt || !force_internal_sync_n)
      sync_ext_r <= 1'b0;
    else if (apb_wr && paddr == acs_pkg::OFF_CTRL)
      sync_ext_r <= pwdata[acs_pkg::CTRL_SYNC_POS];
  end

  // sequencer: idle, arm for external sync, settle, convert
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      cnt_r <= 11'h000;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
          if (cnv_pulse)
          begin
            // external sync only arms; internal starts timing at once
            state_r <= sync_ext_r ? ST_ARM : ST_SETTLE;
            cnt_r <= SETTLE_LAST;
          end
        ST_ARM:
          if (!sync_ext_r)
            state_r <= ST_IDLE; // forced internal: drop the armed start
          else if (ext_pulse)
          begin
            state_r <= ST_SETTLE;
            cnt_r <= SETTLE_LAST;
          end
        ST_SETTLE:
          if (cnt_r == 11'h000)
          begin
            state_r <= ST_CONV;
            cnt_r <= CONV_LAST;
          end
          else
            cnt_r <= cnt_r - 11'h001;
        ST_CONV:
          if (cnt_r == 11'h000)
            state_r <= sync_ext_r ? ST_ARM : ST_IDLE;
          else
            cnt_r <= cnt_r - 11'h001;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // selections latched at the convert pulse and held until complete
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      act_chan_r <= '0;
      act_gain_r <= 2'h0;
    end
    else if (state_r == ST_IDLE && cnv_pulse)
    begin
      act_chan_r <= sw_src[acs_pkg::SW_CHAN_LSB +: acs_pkg::CHAN_W];
      act_gain_r <= {sw_src[acs_pkg::GAIN_SEL_HIGH_POS], sw_src[acs_pkg::GAIN_SEL_LOW_POS]};
    end
  end

  // analog selects; the gain index is the power of two of the gain
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      gain_sel_r <= 4'h1;
      mux_en_r <= 4'h1;
      chan_sel_r <= 32'h1;
    end
    else
    begin
      gain_sel_r <= 4'(acs_onehot({3'h0, act_gain_r}));
      mux_en_r <= 4'(acs_onehot({3'h0, act_chan_r[acs_pkg::CHAN_GROUP_HIGH_POS],
                                 act_chan_r[acs_pkg::CHAN_GROUP_LOW_POS]}));
      chan_sel_r <= acs_onehot(act_chan_r[4:0]);
    end
  end

  // conversion strobes, result buffer and sticky complete flag
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      conv_start_r <= 1'b0;
      conv_done_r <= 1'b0;
      sh_reset_r <= 1'b0;
      result_r <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      conv_start_r <= settle_end;
      conv_done_r <= conv_end;
      sh_reset_r <= conv_end;
      if (conv_end)
        result_r <= adc_q2;
      // a completion in the same cycle as the clearing read wins
      if (conv_end)
        done_r <= 1'b1;
      else if ((apb_rd && paddr == acs_pkg::OFF_RESULT) || convert_instr)
        done_r <= 1'b0;
    end
  end

  // host bus drivers; all lines released high when nothing is presented
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      io_data_n_r <= '1;
      io_addr_n_r <= '1;
    end
    else
    begin
      if (data_strobe)
        io_data_n_r <= ~{{(acs_pkg::IO_W - acs_pkg::RES_W){result_r[acs_pkg::RES_W-1]}},
                         result_r};
      else if (read_status_instr)
      begin
        io_data_n_r <= '1;
        io_data_n_r[acs_pkg::OSW_WC_IDX] <= !wc_overflow;
        io_data_n_r[acs_pkg::OSW_MEM_IDX] <= !mem_overflow;
        io_data_n_r[acs_pkg::CHAN_W-1:0] <= ~act_chan_r;
      end
      else
        io_data_n_r <= '1;
      if (priority_interrupt)
        io_addr_n_r <= ~acs_pkg::TRAP_ADDR;
      else if (dch_read_req)
        io_addr_n_r <= ~acs_pkg::WC_DATA_ADDR;
      else if (dch_write_req && mode_r == acs_pkg::MODE_RANDOM)
        io_addr_n_r <= ~acs_pkg::WC_STATUS_ADDR;
      else
        io_addr_n_r <= '1;
    end
  end

  // apb read data registered in the setup cycle, so no wait states
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      prdata_r <= 32'h0;
    else if (apb_setup && !pwrite)
    begin
      prdata_r <= 32'h0;
      case (paddr)
        acs_pkg::OFF_CTRL:
        begin
          prdata_r[acs_pkg::CTRL_MODE_LSB +: 2] <= mode_r;
          prdata_r[acs_pkg::CTRL_SYNC_POS] <= sync_ext_r;
        end
        acs_pkg::OFF_STATUS_WORD:
          prdata_r[8:0] <= sw_r;
        acs_pkg::OFF_RESULT:
        begin
          prdata_r[acs_pkg::RES_W-1:0] <= result_r;
          prdata_r[acs_pkg::RES_DONE_POS] <= done_r;
        end
        acs_pkg::OFF_STATE:
        begin
          prdata_r[acs_pkg::ST_CHAN_LSB +: acs_pkg::CHAN_W] <= act_chan_r;
          prdata_r[acs_pkg::ST_GAIN_LSB +: 2] <= act_gain_r;
          prdata_r[acs_pkg::ST_BUSY_POS] <= (state_r != ST_IDLE);
          prdata_r[acs_pkg::ST_SYNC_POS] <= sync_ext_r;
          prdata_r[acs_pkg::ST_WC_POS] <= wc_overflow;
          prdata_r[acs_pkg::ST_MEM_POS] <= mem_overflow;
        end
        default:
          prdata_r <= 32'h0;
      endcase
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign gain_sel = gain_sel_r;
  assign mux_en = mux_en_r;
  assign chan_sel = chan_sel_r;
  assign sync_source_select = sync_ext_r;
  assign conv_start = conv_start_r;
  assign conv_done = conv_done_r;
  assign sh_reset = sh_reset_r;
  assign busy = (state_r != ST_IDLE);
  assign io_data_n = io_data_n_r;
  assign io_addr_n = io_addr_n_r;

  // cycles spent in the current state before this one, for the timing checks
  logic [10:0] h_cnt;
  acs_state_t h_state;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      h_cnt <= 11'h000;
      h_state <= ST_IDLE;
    end
    else
    begin
      h_state <= state_r;
      h_cnt <= (state_r != h_state) ? 11'h001 : h_cnt + 11'h001;
    end
  end

  property p_settle_len;
    @(posedge sys_clk) disable iff (rst)
    settle_end |-> (h_cnt == SETTLE_LAST);
  endproperty
  a_settle_len: assert property (p_settle_len) else $error("settle length wrong");

  property p_conv_len;
    @(posedge sys_clk) disable iff (rst)
    conv_end |-> (h_cnt == CONV_LAST) ##1 conv_done;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_ext_hold;
    @(posedge sys_clk) disable iff (rst)
    (state_r == ST_ARM && !ext_pulse) |=> (state_r != ST_SETTLE);
  endproperty
  a_ext_hold: assert property (p_ext_hold) else $error("started without sync");

  property p_force_int;
    @(posedge sys_clk) disable iff (rst)
    priority_interrupt |=> !sync_source_select;
  endproperty
  a_force_int: assert property (p_force_int) else $error("sync not forced");

  property p_gain8;
    @(posedge sys_clk) disable iff (rst)
    (act_gain_r == 2'h3) [*2] |-> (gain_sel == 4'h8);
  endproperty
  a_gain8: assert property (p_gain8) else $error("gain decode wrong");

  property p_sh_reset;
    @(posedge sys_clk) disable iff (rst)
    conv_done |-> sh_reset && (result_r == $past(adc_q2));
  endproperty
  a_sh_reset: assert property (p_sh_reset) else $error("sample reset missing");

  property p_hold_sel;
    @(posedge sys_clk) disable iff (rst)
    (state_r == ST_CONV) ##1 (state_r == ST_CONV) |-> $stable(act_chan_r) && $stable(act_gain_r);
  endproperty
  a_hold_sel: assert property (p_hold_sel) else $error("selection changed");

  property p_trap;
    @(posedge sys_clk) disable iff (rst)
    priority_interrupt |=> (io_addr_n == 6'h10);
  endproperty
  a_trap: assert property (p_trap) else $error("trap lines wrong");

  property p_del;
    @(posedge sys_clk) disable iff (rst)
    (convert_instr && del_r == 11'h000 && mode_r == acs_pkg::MODE_PROG
     && state_r == ST_IDLE && !sync_ext_r) |-> ##DEL_CYC cnv_pulse ##1 (state_r == ST_SETTLE);
  endproperty
  a_del: assert property (p_del) else $error("convert delay wrong");

  property p_strobe;
    @(posedge sys_clk) disable iff (rst)
    data_strobe |=> (io_data_n[acs_pkg::RES_W-1:0] == ~$past(result_r));
  endproperty
  a_strobe: assert property (p_strobe) else $error("data drive wrong");

endmodule : acs_top

// [verif/acs_host.sv]
// host side model: instruction pulses and data channel levels of the io bus
// assumes the sequencer and this model share sys_clk; pulses last one cycle
module acs_host
(
  input wire logic sys_clk,
  output logic convert_instr,
  output logic read_status_instr,
  output logic priority_interrupt,
  output logic data_strobe,
  output logic dch_read_req,
  output logic dch_write_req,
  output logic dch_flag,
  output logic wc_overflow,
  output logic mem_overflow
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] pulse_r = 6'h00; // one bit per instruction pulse
  logic [2:0] lvl_r = 3'h0; // data channel flag, word count and memory overflow
  assign {dch_write_req, dch_read_req, priority_interrupt} = pulse_r[5:3];
  assign {data_strobe, read_status_instr, convert_instr} = pulse_r[2:0];
  assign {dch_flag, wc_overflow, mem_overflow} = lvl_r;

  // raise one pulse right after an edge, drop it after the next edge
  task automatic strobe(input int idx);
    @(posedge sys_clk);
    pulse_r[idx] <= 1'b1;
    @(posedge sys_clk);
    pulse_r <= 6'h00;
  endtask : strobe

  // levels change only right after an edge, like the real channel logic
  task automatic set_lv(input logic [2:0] v);
    lvl_r <= v;
  endtask : set_lv
endmodule : acs_host

// [verif/acs_top_test.sv]
// self-checking bench: apb master, host model and an expectation queue
// assumes the sequencer is built with short settle, convert and delay counts
module acs_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ST = 4; // shortened settle count
  localparam int CV = 20; // shortened conversion count
  localparam int DL = 3; // shortened instruction delay
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic convert_instr, read_status_instr, priority_interrupt, data_strobe;
  logic dch_read_req, dch_write_req, dch_flag, wc_overflow, mem_overflow;
  logic force_internal_sync_n; // active low force to internal sync
  logic ext_sync_pin;
  logic [12:0] adc_data_pin;
  logic [3:0] gain_sel, mux_en;
  logic [31:0] chan_sel;
  logic sync_source_select, conv_start, conv_done, sh_reset, busy;
  logic [17:0] io_data_n;
  logic [5:0] io_addr_n;
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0; // cycle count, also the hang limit
  int t0 = 0; // cycle of the last conversion start
  int n_start = 0; // conversions started so far
  int lat, n;
  logic [3:0] g0; // gain seen at conversion start
  logic [31:0] q;
  logic err_s; // slave error of the last transfer
  int exp_q[$]; // expected converter results in order

  acs_top #(.SETTLE_CYC(ST), .CONV_CYC(CV), .DEL_CYC(DL)) i_dut (.sys_clk, .rst, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .convert_instr,
    .read_status_instr, .priority_interrupt, .force_internal_sync_n, .data_strobe,
    .dch_read_req, .dch_write_req, .dch_flag, .wc_overflow, .mem_overflow, .ext_sync_pin,
    .adc_data_pin, .gain_sel, .mux_en, .chan_sel, .sync_source_select, .conv_start,
    .conv_done, .sh_reset, .busy, .io_data_n, .io_addr_n);
  acs_host i_host (.sys_clk, .convert_instr, .read_status_instr, .priority_interrupt,
    .data_strobe, .dch_read_req, .dch_write_req, .dch_flag, .wc_overflow, .mem_overflow);

  // 50 MHz clock
  always #10 sys_clk = ~sys_clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_cyc(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi)
    begin
      n_errors++;
      $display("[FAIL] %0t delay %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_cyc

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run

  // one apb transfer; an idle edge follows so back to back calls never collide
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end
    while (pready !== 1'b1);
    q = prdata;
    err_s = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  // count edges until a start (or a done) pulse is seen, bounded
  task automatic wait_ev(input logic on_done, output int cnt);
    cnt = 0;
    do
    begin
      @(posedge sys_clk);
      cnt++;
    end
    while ((on_done ? conv_done : conv_start) !== 1'b1 && cnt < 200);
  endtask : wait_ev

  // random mode: load a status word, check decode, timing, result and bus words
  task automatic run_random(input logic [1:0] g, input logic [6:0] ch);
    logic [12:0] v;
    logic [2:0] lv;
    @(posedge sys_clk);
    v = 13'($urandom);
    lv = {1'b0, 2'($urandom)};
    adc_data_pin <= v;
    i_host.set_lv(lv);
    exp_q.push_back(int'(v));
    apb(1'b1, 12'h004, {23'h0, g, ch});
    wait_ev(1'b0, lat);
    chk_cyc(lat, ST - 1, ST + 2);
    chk(gain_sel, 32'h1 << g);
    chk(mux_en, 32'h1 << ch[6:5]);
    chk(chan_sel, 32'h1 << ch[4:0]);
    wait_ev(1'b1, lat);
    apb(1'b0, 12'h008, 32'h0);
    chk(q, 32'h10000 | 32'(exp_q.pop_front()));
    apb(1'b0, 12'h00C, 32'h0);
    chk(q[9:0], {1'b0, g, ch});
    i_host.strobe(2);
    @(negedge sys_clk);
    chk(io_data_n, 18'(~{{5{v[12]}}, v}));
    i_host.strobe(1);
    @(negedge sys_clk);
    chk(io_data_n, 18'(~({4'h0, lv[1:0], 12'h000} | ch)));
  endtask : run_random

  // hang limit and per-cycle watch of the conversion pulses
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_errors++;
      complete_run();
    end
    if (!rst)
    begin
      chk(sh_reset, conv_done);
      if (conv_start)
      begin
        t0 = cyc;
        g0 = gain_sel;
        n_start++;
      end
      if (conv_done)
      begin
        chk_cyc(cyc - t0, CV, CV);
        chk(gain_sel, g0);
      end
    end
  end

  initial
  begin
    paddr <= 12'h000;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    pwdata <= 32'h0;
    force_internal_sync_n <= 1'b1;
    ext_sync_pin <= 1'b0;
    adc_data_pin <= 13'h0000;
    n = $urandom(32'h689937E8);
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    chk({busy, sync_source_select, io_addr_n, gain_sel, mux_en}, 16'h3F11);
    chk(io_data_n, 18'h3FFFF);
    @(posedge sys_clk);
    apb(1'b0, 12'h010, 32'h0);
    chk(err_s, 1'b1);
    chk(q, 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    for (int g = 0; g < 4; g++)
      run_random(2'(g), 7'($urandom));
    i_host.strobe(4);
    @(negedge sys_clk);
    chk(io_addr_n, 6'h29);
    i_host.strobe(5);
    @(negedge sys_clk);
    chk(io_addr_n, 6'h2B);
    // external sync: nothing starts until the pin pulses, then once per pulse
    apb(1'b1, 12'h000, 32'h5);
    chk(sync_source_select, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h5);
    n = n_start;
    apb(1'b1, 12'h004, {23'h0, 9'($urandom)});
    repeat (30) @(posedge sys_clk);
    chk(n_start, n);
    for (int k = 0; k < 2; k++)
    begin
      ext_sync_pin <= 1'b1;
      wait_ev(1'b0, lat);
      chk_cyc(lat, ST + 2, ST + 6);
      wait_ev(1'b1, lat);
      ext_sync_pin <= 1'b0;
      repeat (5) @(posedge sys_clk);
    end
    force_internal_sync_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    force_internal_sync_n <= 1'b1;
    ext_sync_pin <= 1'b1;
    repeat (30) @(posedge sys_clk);
    ext_sync_pin <= 1'b0;
    chk({sync_source_select, busy}, 2'b00);
    chk(n_start, n + 2);
    apb(1'b1, 12'h000, 32'h4);
    i_host.strobe(3);
    @(negedge sys_clk);
    chk({sync_source_select, io_addr_n}, 7'h10);
    // program control: the convert instruction starts after its delay
    apb(1'b1, 12'h000, 32'h0);
    i_host.strobe(0);
    wait_ev(1'b0, lat);
    chk_cyc(lat, DL + ST - 1, DL + ST + 3);
    wait_ev(1'b1, lat);
    // sequential: each completion restarts until word count overflows
    i_host.set_lv(3'h4);
    apb(1'b1, 12'h000, 32'h2);
    i_host.strobe(0);
    wait_ev(1'b0, lat);
    chk_cyc(lat, DL + ST - 1, DL + ST + 3);
    wait_ev(1'b1, lat);
    wait_ev(1'b0, lat);
    chk_cyc(lat, ST, ST + 3);
    i_host.set_lv(3'h6);
    wait_ev(1'b1, lat);
    n = n_start;
    repeat (40) @(posedge sys_clk);
    chk(busy, 1'b0);
    chk(n_start, n);
    complete_run();
  end
endmodule : acs_top_test
